/* hw/port2_gpio.sv */
// eight-bit port: general-purpose pins or low data-bus byte by mode
`default_nettype none
module port2_gpio
  import port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] mode_i,
  input wire logic sw_standby_i,
  input wire logic hw_standby_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [PORT_W-1:0] bus_dout_i,
  input wire logic [PORT_W-1:0] bus_oe_i,
  output logic [PORT_W-1:0] bus_din_o,
  input wire logic [PORT_W-1:0] pin_i,
  output logic [PORT_W-1:0] pin_o,
  output logic [PORT_W-1:0] pin_oe_o
);
  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] data;
    logic [7:0] rdata;
    pin_drive_t drv;
    pin_owner_t owner;
    logic [PORT_W-1:0] bus_din;
  } port_state_t;

  port_state_t st_q, st_d;
  logic [PORT_W-1:0] pin_s;
  logic hw_stby_s;
  logic [PORT_W-1:0] rb_value;
  logic io_mode;
  pin_drive_t bus_drv;

  // pins and the standby pin come from outside the clock domain
  sync2 #(.W(PORT_W)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_s)
  );

  sync2 #(.W(1)) u_stby_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(hw_standby_i),
    .sync_o(hw_stby_s)
  );

  // mode decode; mode 0 is not a documented mode and is treated as bus
  assign io_mode = is_io_mode(mode_i);
  assign bus_drv.dout = bus_dout_i;
  assign bus_drv.oe = bus_oe_i;

  // read path looks at the registers as they stand at the strobe
  port_readback u_readback (
    .io_mode_i(io_mode),
    .dir_i(st_q.dir),
    .data_i(st_q.data),
    .sense_i(pin_s),
    .value_o(rb_value)
  );

  // next state: registers, ownership, read data and pin drive
  always_comb begin
    st_d = st_q;
    st_d.rdata = RD_IDLE;
    st_d.bus_din = pin_s;
    // ownership of the pins
    if (hw_stby_s) begin
      st_d.owner = OWN_FLOAT;
    end else if (io_mode) begin
      st_d.owner = OWN_IO;
    end else if (sw_standby_i) begin
      st_d.owner = OWN_FLOAT;
    end else begin
      st_d.owner = OWN_BUS;
    end
    // register writes; hardware standby holds both registers cleared
    if (hw_stby_s) begin
      st_d.dir = DIR_RST;
      st_d.data = DATA_RST;
    end else if (wr_i) begin
      if (addr_i == DIR_OFS) begin
        st_d.dir = wdata_i;
      end
      if (addr_i == DATA_OFS && io_mode) begin
        st_d.data = wdata_i;
      end
    end
    // register reads; unmapped addresses answer zero
    if (rd_i) begin
      if (addr_i == DIR_OFS) begin
        st_d.rdata = ALL_ONES;
      end else if (addr_i == DATA_OFS) begin
        st_d.rdata = rb_value;
      end
    end
    // drive from next values so a write shows one cycle later
    st_d.drv = drive_f(st_d.owner, st_d.dir, st_d.data, bus_drv);
  end

  // software standby has no effect on either register here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.dir <= DIR_RST;
      st_q.data <= DATA_RST;
      st_q.rdata <= RD_IDLE;
      st_q.drv <= '0;
      st_q.owner <= OWN_FLOAT;
      st_q.bus_din <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign pin_o = st_q.drv.dout;
  assign pin_oe_o = st_q.drv.oe;
  assign bus_din_o = st_q.bus_din;
endmodule // port2_gpio
`default_nettype wire

/* hw/port_pkg.sv */
// shared constants, types and drive helpers of the eight-bit port
`default_nettype none
package port_pkg;
  localparam int PORT_W = 8;
  // register byte addresses
  localparam logic [15:0] DIR_OFS = 16'hFE81;
  localparam logic [15:0] DATA_OFS = 16'hFE83;
  // reset values and fixed read answers
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] RD_IDLE = 8'h00;
  // operating modes in which the pins are general-purpose
  localparam logic [2:0] MODE_IO_LO = 3'h2;
  localparam logic [2:0] MODE_IO_HI = 3'h7;

  // who owns the pins
  typedef enum logic [2:0] {
    OWN_IO = 3'b001,
    OWN_BUS = 3'b010,
    OWN_FLOAT = 3'b100
  } pin_owner_t;

  typedef struct packed {
    logic [PORT_W-1:0] dout;
    logic [PORT_W-1:0] oe;
  } pin_drive_t;

  function automatic logic is_io_mode(input logic [2:0] mode);
    return (mode == MODE_IO_LO) || (mode == MODE_IO_HI);
  endfunction

  // pin drive for a given owner; bus modes ignore both port registers
  function automatic pin_drive_t drive_f(
    input pin_owner_t owner,
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] data,
    input pin_drive_t bus
  );
    pin_drive_t r;
    r.dout = '0;
    r.oe = '0;
    case (owner)
      OWN_IO: begin
        r.dout = data;
        r.oe = dir;
      end
      OWN_BUS: r = bus;
      OWN_FLOAT: r.oe = '0;
      default: r.oe = '0;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

/* hw/sync2.sv */
// two-flop synchroniser for levels arriving from outside the clock domain
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_q, st_d;

  // first stage is read only by the second stage
  always_comb begin
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule // sync2
`default_nettype wire

/* hw/port_readback.sv */
// read-back value of the data register: latch, pin level or all ones
`default_nettype none
module port_readback
  import port_pkg::*;
(
  input wire logic io_mode_i,
  input wire logic [PORT_W-1:0] dir_i,
  input wire logic [PORT_W-1:0] data_i,
  input wire logic [PORT_W-1:0] sense_i,
  output logic [PORT_W-1:0] value_o
);
  // per bit in io modes: outputs return the latch, inputs the pin; bus modes read all ones
  always_comb begin
    if (io_mode_i) begin
      value_o = (dir_i & data_i) | (~dir_i & sense_i);
    end else begin
      value_o = ALL_ONES;
    end
  end
endmodule // port_readback
`default_nettype wire

/* dv/port_props.sv */
// assertions on the register read port and the pin drivers
`default_nettype none
module port_props
  import port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] mode_i,
  input wire logic sw_standby_i,
  input wire logic hw_standby_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic io = is_io_mode(mode_i);
  // standby pin low long enough to have left the synchroniser
  sequence calm_s;
    !hw_standby_i [*4];
  endsequence
  a_dir_reads_ones: assert property (rd_i && addr_i == DIR_OFS |=> rdata_o == ALL_ONES)
    else $error("dir read");
  a_bus_data_ones: assert property (rd_i && addr_i == DATA_OFS && !io |=> rdata_o == ALL_ONES)
    else $error("bus data read");
  a_idle_read: assert property (!rd_i |=> rdata_o == RD_IDLE)
    else $error("stale read");
  a_unmapped_zero: assert property (rd_i && addr_i != DIR_OFS && addr_i != DATA_OFS |=> rdata_o == RD_IDLE)
    else $error("unmapped read");
  a_dir_to_oe: assert property (calm_s ##0 io && wr_i && addr_i == DIR_OFS |=> pin_oe_o == $past(wdata_i))
    else $error("dir write");
  a_data_to_pin: assert property (calm_s ##0 io && wr_i && addr_i == DATA_OFS |=> pin_o == $past(wdata_i))
    else $error("data write");
  a_sw_floats: assert property (!io && sw_standby_i |=> pin_oe_o == 8'h00)
    else $error("sw float");
  a_hw_floats: assert property (hw_standby_i [*4] |=> pin_oe_o == 8'h00)
    else $error("hw float");
endmodule // port_props
bind port2_gpio port_props u_props (.clk_i, .rst_i, .mode_i, .sw_standby_i, .hw_standby_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_o, .pin_oe_o);
`default_nettype wire

/* dv/pin_world.sv */
// outside world on the port pins
`default_nettype none
module pin_world (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // free pins follow a value that the bench changes on each of the 16 io-test passes, so no stale level hides
  assign level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule // pin_world
`default_nettype wire

/* dv/port2_gpio_test.sv */
// self-checking bench for the eight-bit port
`default_nettype none
module port2_gpio_test
  import port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sws = 0, hws = 0, wr = 0, rd = 0;
  logic [2:0] mode = 3'h7;
  logic [15:0] adr = 16'h0000;
  logic [7:0] wd = 8'h00, bo = 8'h00, be = 8'h00, ext = 8'h00, rdat, pin, po, poe, dv, dd, bdi;
  int errors = 0, total_checks = 0, seed = 51;
  port2_gpio u_dut (.clk_i(clk), .rst_i(rst), .mode_i(mode), .sw_standby_i(sws), .hw_standby_i(hws),
    .addr_i(adr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .bus_dout_i(bo), .bus_oe_i(be),
    .bus_din_o(bdi), .pin_i(pin), .pin_o(po), .pin_oe_o(poe));
  pin_world u_world (.pin_o(po), .pin_oe_o(poe), .ext_i(ext), .level_o(pin));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one strobe cycle; returns just after the edge that takes it
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  function automatic logic [7:0] mix(logic [7:0] d, q, p);
    return (d & q) | (~d & p);
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog well past the roughly 140 cycles of the run
  initial begin
    #60000;
    errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    acc(0, DIR_OFS, 8'h00);
    chk(rdat, ALL_ONES);
    chk(poe, DIR_RST);
    chk(po, DATA_RST);
    for (int i = 0; i < 16; i++) begin
      mode <= i[0] ? MODE_IO_LO : MODE_IO_HI;
      ext <= 8'($random(seed));
      dv = 8'($random(seed));
      dd = 8'($random(seed));
      acc(1, DIR_OFS, dv);
      acc(1, DATA_OFS, dd);
      chk(poe, dv);
      chk(po, dd);
      sws <= i[1];
      acc(0, DATA_OFS, 8'h00);
      chk(rdat, mix(dv, dd, ext));
      chk(poe, dv);
    end
    $display("io test done");
    for (int m = 0; m < 7; m++) begin
      if (m == 2) continue;
      mode <= 3'(m);
      be <= 8'($random(seed));
      bo <= 8'($random(seed));
      sws <= m[0];
      acc(1, DATA_OFS, ~dd);
      acc(0, DATA_OFS, 8'h00);
      chk(rdat, ALL_ONES);
      chk(poe, sws ? 8'h00 : be);
      chk(po, sws ? 8'h00 : bo);
      chk(bdi, sws ? ext : mix(be, bo, ext));
    end
    sws <= 0;
    mode <= MODE_IO_HI;
    // let bus-driven levels leave the pin synchroniser before sensing inputs
    repeat (3) @(posedge clk);
    acc(0, DATA_OFS, 8'h00);
    chk(rdat, mix(dv, dd, ext));
    hws <= 1;
    repeat (5) @(posedge clk);
    #1 chk(poe, 8'h00);
    hws <= 0;
    repeat (3) @(posedge clk);
    acc(0, DATA_OFS, 8'h00);
    chk(rdat, ext);
    acc(0, 16'hFE82, 8'h00);
    chk(rdat, RD_IDLE);
    $display("bus and standby test done");
    print_verdict();
  end
endmodule // port2_gpio_test
`default_nettype wire
